// *** src/nv_defines.svh ***
// Purpose: Shared constants of the non-volatile data access controller
// Assumes: 100 MHz system clock
// Notes:   Offsets, bit positions, reset values and cycle counts
`ifndef NV_DEFINES_SVH
`define NV_DEFINES_SVH

// Store geometry
`define NV_DEPTH        32
`define NV_ADDR_BITS    5

// Register locations; control sits in bank 1, the others answer in either bank
`define NV_CONTROL_OFS  8'h40
`define NV_CONTROL_BANK 1'b1
`define NV_ADDRESS_OFS  8'h1E
`define NV_DATA_OFS     8'h1F

// Control field positions
`define NV_BIT_WEN      3
`define NV_BIT_WTRIG    2
`define NV_BIT_REN      1
`define NV_BIT_RTRIG    0

// Reset values
`define NV_RESET_BYTE   8'h00

// Timing
`define NV_CLK_NS        10
`define NV_WRITE_TIME_NS 2000
`define NV_WRITE_CYCLES  ((`NV_WRITE_TIME_NS + `NV_CLK_NS - 1) / `NV_CLK_NS)
`define NV_READ_TIME_NS  20
`define NV_READ_CYCLES   ((`NV_READ_TIME_NS + `NV_CLK_NS - 1) / `NV_CLK_NS)

`endif

// *** src/nv_pkg.sv ***
// Purpose: Types of the non-volatile data access controller
// Assumes: Nothing
// Notes:   Constants live in nv_defines.svh
package nv_pkg;

  // One-hot cycle states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } nv_state_e;

  typedef logic [7:0] byte_t;

endpackage

// *** src/nv_array_if.sv ***
// Purpose: Carrier between the controller and the storage array
// Assumes: Single clock, read data registered one cycle
// Notes:   ctrl drives the strobes, mem answers
`timescale 1ns/1ps
interface nv_array_if #(
  parameter int AW = 5,
  parameter int DW = 8
);
  logic          wrEn;  // Write strobe, one cycle
  logic          read_enable;  // Read strobe
  logic [AW-1:0] addr;  // Location index
  logic [DW-1:0] wdata; // Byte to store
  logic [DW-1:0] rdata; // Byte fetched

  modport ctrl (output wrEn, read_enable, addr, wdata, input rdata);
  modport mem  (input wrEn, read_enable, addr, wdata, output rdata);
endinterface

// *** src/nv_array.sv ***
// Purpose: Byte-wide non-volatile storage array
// Assumes: Strobes come from the controller only
// Notes:   Contents are not reset, as befits retained memory
`timescale 1ns/1ps
module nv_array #(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input wire logic clk,  // System clock
  nv_array_if.mem  port  // Controller side
);

  logic [7:0] mem [DEPTH];

  // Storage and registered read port
  always_ff @(posedge clk) begin
    if (port.wrEn) begin
      mem[port.addr] <= port.wdata;
    end
    if (port.read_enable) begin
      port.rdata <= mem[port.addr];
    end
  end

endmodule // nv_array

// *** src/nv_write_timer.sv ***
// Purpose: Programming-time timer for write cycles
// Assumes: start is a one-cycle pulse while the timer is idle
// Notes:   Free of the core's pacing; only the system clock is available here
`timescale 1ns/1ps
module nv_write_timer #(
  parameter int CYCLES = 200
) (
  input  wire logic clk,   // System clock
  input  wire logic srst,  // Synchronous reset
  input  wire logic start, // Launch pulse
  output logic      busy,  // Programming in progress
  output logic      done   // Last cycle of programming
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  // Load on start, then count down to zero
  always_comb begin
    next_count = count;
    if (start) begin
      next_count = CW'(CYCLES);
    end else if (count != '0) begin
      next_count = count - CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign busy = (count != '0);
  assign done = (count == CW'(1));

  a_done_in_busy: assert property (@(posedge clk) disable iff (srst)
    done |-> busy ##1 !busy) else $error("timer done not followed by idle");
  c_timer_run: cover property (@(posedge clk) disable iff (srst) done);

endmodule // nv_write_timer

// *** src/eeprom_data_access_ctrl.sv ***
// Purpose: Byte access controller for a 32 x 8 non-volatile data store
// Assumes: Core register port is synchronous; bank and indirect flags come with each access
// Notes:   Control register answers only to indirect access in bank 1
//
// Functional notes
// - Store holds 32 bytes, not memory mapped, one byte per operation.
// - Address register keeps a 5-bit index, resets to zero, top bits read zero.
// - Data register is 8-bit read/write, resets zero, carries write and read data.
// - Control register sits at 40H bank 1, reachable only indirectly.
// - Control bit 3 is write enable; while clear no write starts.
// - Bit 2 starts a write only if enable already set; cleared at end.
// - Bit 0 starts a read if enabled; cleared at end with data loaded.
// - Read data stays in the data register until the next operation.
// - Write is timed by an internal timer; trigger stays set throughout.
// - Reset clears write enable so nothing is written until re-enabled.
// - Interrupt request is raised when a read or write cycle ends.
// - Write end sets both the block flag and the shared flag.
// - Vector jump needs global, block and shared enables and a free stack.
// - Servicing clears only the shared flag; software clears the block flag.
`timescale 1ns/1ps
`include "nv_defines.svh"
module eeprom_data_access_ctrl
  import nv_pkg::*;
#(
  parameter int WRITE_CYCLES = `NV_WRITE_CYCLES,
  parameter int READ_CYCLES  = `NV_READ_CYCLES
) (
  input  wire logic       clk,           // System clock
  input  wire logic       srst,          // Synchronous reset, high
  input  wire logic [7:0] regAddr,       // Register offset
  input  wire logic       regIndirect,   // Access made through the indirect register
  input  wire logic       bankSelect,    // Data bank of this access
  input  wire logic       regWr,         // Write strobe
  input  wire logic       regRd,         // Read strobe
  input  wire logic [7:0] regWdata,      // Write data
  output logic      [7:0] regRdata,      // Read data, one cycle after regRd
  input  wire logic       globalIntEn,   // Global interrupt enable
  input  wire logic       nvIrqEnable,   // Block interrupt enable
  input  wire logic       mfIntEnable,   // Shared interrupt enable
  input  wire logic       stackFull,     // No room for a return address
  input  wire logic       irqServiced,   // Shared vector taken
  input  wire logic       nvFlagClear,   // Software clears the block flag
  output logic            nvIrqFlag,     // Block request flag
  output logic            mfIrqFlag,     // Shared request flag
  output logic            vectorRequest, // Jump to the shared vector
  output logic            busy           // Cycle in progress
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam int AW = `NV_ADDR_BITS;
  nv_state_e     state;
  nv_state_e     next_state;
  logic [AW-1:0] nvAddress;
  logic [AW-1:0] next_nvAddress;
  byte_t         nvData;
  byte_t         next_nvData;
  logic          writeEnable;
  logic          next_writeEnable;
  logic          writeTrigger;
  logic          next_writeTrigger;
  logic          readEnable;
  logic          next_readEnable;
  logic          readTrigger;
  logic          next_readTrigger;
  logic [AW-1:0] capAddr;
  logic [AW-1:0] next_capAddr;
  byte_t         capData;
  byte_t         next_capData;
  logic [1:0]    readCnt;
  logic [1:0]    next_readCnt;
  byte_t         next_regRdata;
  logic          next_nvIrqFlag;
  logic          next_mfIrqFlag;
  logic          next_vectorRequest;
  logic          next_busy;
  logic          ctrlHit;
  logic          addrHit;
  logic          dataHit;
  logic          startWrite;
  logic          startRead;
  logic          readEnd;
  logic          writeEnd;
  logic          timerBusy;
  logic          timerDone;
  nv_array_if #(.AW(AW), .DW(8)) arr ();

  // Byte view of the control register
  function automatic byte_t ctrlByte(input logic wen, input logic wt,
                                     input logic ren, input logic rt);
    byte_t b;
    b = `NV_RESET_BYTE;
    b[`NV_BIT_WEN]   = wen;
    b[`NV_BIT_WTRIG] = wt;
    b[`NV_BIT_REN]   = ren;
    b[`NV_BIT_RTRIG] = rt;
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Control needs the indirect path and bank 1; a direct access never reaches it
  assign ctrlHit = regIndirect && (bankSelect == `NV_CONTROL_BANK)
                 && (regAddr == `NV_CONTROL_OFS);
  assign addrHit = !regIndirect && (regAddr == `NV_ADDRESS_OFS);
  assign dataHit = !regIndirect && (regAddr == `NV_DATA_OFS);

  // Triggers qualify on enables already stored, so setting both at once fails
  assign startWrite = (state == ST_IDLE) && regWr && ctrlHit
                    && regWdata[`NV_BIT_WTRIG] && writeEnable;
  assign startRead  = (state == ST_IDLE) && regWr && ctrlHit && !startWrite
                    && regWdata[`NV_BIT_RTRIG] && readEnable;
  assign readEnd    = (state == ST_READ)
                    && (readCnt == 2'(READ_CYCLES - 1));
  assign writeEnd   = (state == ST_WRITE) && timerDone;

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  // Software writes, with hardware updates taking priority
  always_comb begin
    next_nvAddress    = nvAddress;
    next_nvData       = nvData;
    next_writeEnable  = writeEnable;
    next_writeTrigger = writeTrigger;
    next_readEnable   = readEnable;
    next_readTrigger  = readTrigger;
    if (regWr && addrHit) begin
      next_nvAddress = regWdata[AW-1:0];
    end
    if (regWr && dataHit) begin
      next_nvData = regWdata;
    end
    if (regWr && ctrlHit) begin
      next_writeEnable = regWdata[`NV_BIT_WEN];
      next_readEnable  = regWdata[`NV_BIT_REN];
    end
    if (startWrite) begin
      next_writeTrigger = 1'b1;
    end
    if (startRead) begin
      next_readTrigger = 1'b1;
    end
    // Read result lands last, so it wins over a same-cycle data write
    if (readEnd) begin
      next_nvData      = arr.rdata;
      next_readTrigger = 1'b0;
    end
    if (writeEnd) begin
      next_writeTrigger = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      nvAddress    <= '0;
      nvData       <= `NV_RESET_BYTE;
      writeEnable  <= 1'b0;
      writeTrigger <= 1'b0;
      readEnable   <= 1'b0;
      readTrigger  <= 1'b0;
    end else begin
      nvAddress    <= next_nvAddress;
      nvData       <= next_nvData;
      writeEnable  <= next_writeEnable;
      writeTrigger <= next_writeTrigger;
      readEnable   <= next_readEnable;
      readTrigger  <= next_readTrigger;
    end
  end

  // Registered read mux; unmapped offsets read as zero
  always_comb begin
    next_regRdata = regRdata;
    if (regRd) begin
      next_regRdata = `NV_RESET_BYTE;
      if (ctrlHit) begin
        next_regRdata = ctrlByte(writeEnable, writeTrigger, readEnable, readTrigger);
      end else if (addrHit) begin
        next_regRdata = {{(8-AW){1'b0}}, nvAddress};
      end else if (dataHit) begin
        next_regRdata = nvData;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      regRdata <= `NV_RESET_BYTE;
    end else begin
      regRdata <= next_regRdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer

  // Address and data are frozen at launch so later software writes cannot disturb the cycle
  always_comb begin
    next_state   = state;
    next_capAddr = capAddr;
    next_capData = capData;
    next_readCnt = readCnt;
    case (state)
      ST_IDLE: begin
        next_readCnt = '0;
        if (startWrite) begin
          next_state   = ST_WRITE;
          next_capAddr = nvAddress;
          next_capData = nvData;
        end else if (startRead) begin
          next_state   = ST_READ;
          next_capAddr = nvAddress;
        end
      end
      ST_READ: begin
        next_readCnt = readCnt + 2'd1;
        if (readEnd) begin
          next_state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        // Trigger held until the programming timer runs out
        if (writeEnd) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state   <= ST_IDLE;
      capAddr <= '0;
      capData <= `NV_RESET_BYTE;
      readCnt <= '0;
    end else begin
      state   <= next_state;
      capAddr <= next_capAddr;
      capData <= next_capData;
      readCnt <= next_readCnt;
    end
  end

  // Array strobes; write lands on the timer's last cycle
  assign arr.read_enable  = (state == ST_READ);
  assign arr.wrEn  = writeEnd;
  assign arr.addr  = capAddr;
  assign arr.wdata = capData;

  nv_array #(.DEPTH(`NV_DEPTH), .AW(AW)) u_array (
    .clk  (clk),
    .port (arr)
  );

  nv_write_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
    .clk   (clk),
    .srst  (srst),
    .start (startWrite),
    .busy  (timerBusy),
    .done  (timerDone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags

  // Set wins over clear for both flags
  always_comb begin
    next_nvIrqFlag = (nvIrqFlag && !nvFlagClear) || readEnd || writeEnd;
    next_mfIrqFlag = (mfIrqFlag && !irqServiced) || readEnd || writeEnd;
    next_vectorRequest = globalIntEn && nvIrqEnable && mfIntEnable
                       && !stackFull && nvIrqFlag && mfIrqFlag;
    next_busy = (next_state != ST_IDLE);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      nvIrqFlag     <= 1'b0;
      mfIrqFlag     <= 1'b0;
      vectorRequest <= 1'b0;
      busy          <= 1'b0;
    end else begin
      nvIrqFlag     <= next_nvIrqFlag;
      mfIrqFlag     <= next_mfIrqFlag;
      vectorRequest <= next_vectorRequest;
      busy          <= next_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_addr_upper_zero: assert property (
    regRd && addrHit |=> regRdata[7:AW] == '0) else $error("address top bits not zero");
  a_ctrl_direct_blocked: assert property (
    regWr && !regIndirect |=> $stable(writeEnable) && $stable(readEnable))
    else $error("direct access changed control");
  a_wtrig_needs_wen: assert property (
    $rose(writeTrigger) |-> $past(writeEnable)) else $error("write started while disabled");
  a_rtrig_needs_ren: assert property (
    $rose(readTrigger) |-> $past(readEnable)) else $error("read started while disabled");
  a_wtrig_held: assert property (
    $rose(writeTrigger) |-> (writeTrigger && timerBusy) [*8]) else $error("write trigger dropped early");
  a_read_result: assert property (
    readEnd |=> !readTrigger && nvData == $past(arr.rdata)) else $error("read result wrong");
  a_data_stable: assert property (
    state == ST_IDLE && !(regWr && dataHit) |=> $stable(nvData)) else $error("data changed");
  a_write_flags: assert property (
    $fell(writeTrigger) |-> nvIrqFlag && mfIrqFlag) else $error("write end flags missing");
  a_vector_gate: assert property (
    vectorRequest |-> $past(globalIntEn && nvIrqEnable && mfIntEnable && !stackFull))
    else $error("vector without enables");
  a_service_keeps_nv: assert property (
    irqServiced && nvIrqFlag && !nvFlagClear && !readEnd && !writeEnd |=> nvIrqFlag && !mfIrqFlag)
    else $error("service flag handling wrong");
  a_capture_held: assert property (
    state != ST_IDLE && next_state != ST_IDLE |=> $stable(capAddr) && $stable(capData))
    else $error("captured values changed");
  a_reset_wen: assert property (@(posedge clk) disable iff (1'b0)
    srst |=> !writeEnable) else $error("reset left write enabled");
  c_read_done: cover property (readEnd);
  c_write_done: cover property (writeEnd);
  c_vector: cover property ($rose(vectorRequest));

endmodule // eeprom_data_access_ctrl

// *** verification/core_model.sv ***
// Purpose: Core-side software model that makes the register accesses
// Assumes: One access per call; signals change 1 ns after the clock edge
// Notes:   Control is reached only through the pointer path in bank 1
`timescale 1ns/1ps
module core_model (
  input  wire logic       clk,         // System clock
  output logic      [7:0] regAddr,     // Register offset
  output logic            regIndirect, // Pointer path in use
  output logic            bankSelect,  // Bank of the access
  output logic            regWr,       // Write strobe
  output logic            regRd,       // Read strobe
  output logic      [7:0] regWdata,    // Write data
  input  wire logic [7:0] regRdata     // Read data
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero; bank 0 keeps the control register out of reach
  initial begin
    {regAddr, regWdata} = 16'h0000;
    {regIndirect, bankSelect, regWr, regRd} = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One access: path is {indirect, bank}; read data is taken after the edge
  task automatic acc(input logic wr, input logic [1:0] path, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    #1;
    {regIndirect, bankSelect} = path;
    regAddr = a;
    regWdata = d;
    {regWr, regRd} = {wr, !wr};
    @(posedge clk);
    #1;
    q = regRdata;
    // Bank dropped at once so a stray write cannot hit control
    {regWr, regRd, bankSelect} = 3'h0;
  endtask
endmodule // core_model

// *** verification/testbench.sv ***
// Purpose: Self-checking bench for the non-volatile access controller
// Assumes: Short programming time set by parameter
// Notes:   Expected bytes come from the register layout and stored values
`timescale 1ns/1ps
`include "nv_defines.svh"
module testbench;
  localparam int WC = 16;
  localparam int RC = 2;
  localparam logic [7:0] A = `NV_ADDRESS_OFS;
  localparam logic [7:0] D = `NV_DATA_OFS;
  localparam logic [7:0] C = `NV_CONTROL_OFS;
  logic       clk, srst, regIndirect, bankSelect, regWr, regRd, busy;
  logic       globalIntEn, nvIrqEnable, mfIntEnable, stackFull;
  logic       irqServiced, nvFlagClear, nvIrqFlag, mfIrqFlag, vectorRequest;
  logic [7:0] regAddr, regWdata, regRdata, q;
  int         checks, fail_count, cycles, run;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, cycle ceiling and busy-length counter
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (busy === 1'b1) run++;
    if (cycles == 5000) begin
      fail_count++;
      conclude();
    end
  end

  core_model core (.clk(clk), .regAddr(regAddr), .regIndirect(regIndirect),
    .bankSelect(bankSelect), .regWr(regWr), .regRd(regRd), .regWdata(regWdata),
    .regRdata(regRdata));
  eeprom_data_access_ctrl #(.WRITE_CYCLES(WC), .READ_CYCLES(RC)) dut (.clk(clk),
    .srst(srst), .regAddr(regAddr), .regIndirect(regIndirect), .bankSelect(bankSelect),
    .regWr(regWr), .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata),
    .globalIntEn(globalIntEn), .nvIrqEnable(nvIrqEnable), .mfIntEnable(mfIntEnable),
    .stackFull(stackFull), .irqServiced(irqServiced), .nvFlagClear(nvFlagClear),
    .nvIrqFlag(nvIrqFlag), .mfIrqFlag(mfIrqFlag), .vectorRequest(vectorRequest),
    .busy(busy));

  ////////////////////////////////////////////////////////////////////////////
  // Compare, access and report tasks
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d, input logic [1:0] p);
    core.acc(1'b1, p, a, d, q);
  endtask
  task automatic wc(input logic [7:0] d);
    core.acc(1'b1, 2'h3, C, d, q);
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [1:0] p,
                    input logic [7:0] e);
    logic [7:0] v;
    core.acc(1'b0, p, a, 8'h00, v);
    chk(n, e, v);
  endtask
  // Bounded wait for the cycle to end
  task automatic idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("idle", 8'h00, {7'h00, busy});
  endtask
  task automatic pulse(input logic s, input logic c);
    @(posedge clk);
    #1 {irqServiced, nvFlagClear} = {s, c};
    @(posedge clk);
    #1 {irqServiced, nvFlagClear} = 2'h0;
  endtask
  // Write one byte; mid also pokes registers while programming runs
  task automatic wb(input logic [7:0] a, input logic [7:0] d, input logic mid);
    w(A, a, 2'h0);
    w(D, d, 2'h0);
    wc(8'h08);
    wc(8'h0C);
    run = 0;
    chk("wbusy", 8'h01, {7'h00, busy});
    if (mid) begin
      rc("wtrigHeld", C, 2'h3, 8'h0C);
      w(A, 8'h07, 2'h0);
      w(D, 8'h11, 2'h0);
      wc(8'h0E);
      wc(8'h0F);
    end
    idle();
    chk("wlen", 8'(WC), 8'(run));
  endtask
  task automatic fin(input string n);
    $display("test %s done", n);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {globalIntEn, nvIrqEnable, mfIntEnable, stackFull, irqServiced, nvFlagClear} = 6'h00;
    srst = 1'b1;
    repeat (8) @(posedge clk);
    #1 srst = 1'b0;
    rc("addrRst", A, 2'h0, 8'h00);
    rc("dataRst", D, 2'h0, 8'h00);
    rc("ctrlRst", C, 2'h3, 8'h00);
    chk("outRst", 8'h00, {busy, nvIrqFlag, mfIrqFlag, vectorRequest});
    fin("reset");
    // Unused address bits and refused control paths
    w(A, 8'hFF, 2'h0);
    rc("addrTop", A, 2'h0, 8'h1F);
    w(C, 8'h0A, 2'h0);
    w(C, 8'h0A, 2'h2);
    rc("ctrlRefused", C, 2'h3, 8'h00);
    rc("ctrlDirect", C, 2'h0, 8'h00);
    fin("paths");
    // Triggers that must not launch
    wc(8'h04);
    chk("noWen", 8'h00, {7'h00, busy});
    wc(8'h01);
    chk("noRen", 8'h00, {7'h00, busy});
    wc(8'h0C);
    chk("sameWrite", 8'h00, {7'h00, busy});
    rc("ctrlEnOnly", C, 2'h3, 8'h08);
    fin("refused");
    // Writes at both ends of the store and one in the middle
    wb(8'h00, 8'h5A, 1'b0);
    wb(8'h1F, 8'hC3, 1'b0);
    wb(8'h05, 8'hA5, 1'b1);
    rc("ctrlAfterW", C, 2'h3, 8'h0A);
    chk("flagsW", 8'h03, {6'h00, nvIrqFlag, mfIrqFlag});
    pulse(1'b1, 1'b0);
    chk("svc", 8'h02, {6'h00, nvIrqFlag, mfIrqFlag});
    pulse(1'b0, 1'b1);
    chk("swClr", 8'h00, {6'h00, nvIrqFlag, mfIrqFlag});
    fin("write");
    // Read back; the middle location kept the byte captured at launch
    for (int i = 0; i < 3; i++) begin
      w(A, (i == 0) ? 8'h00 : (i == 1) ? 8'h1F : 8'h05, 2'h0);
      wc(8'h02);
      wc(8'h03);
      run = 0;
      idle();
      chk("rlen", 8'(RC), 8'(run));
      rc("rdata", D, 2'h0, (i == 0) ? 8'h5A : (i == 1) ? 8'hC3 : 8'hA5);
      rc("rtrigClr", C, 2'h3, 8'h02);
    end
    w(A, 8'h00, 2'h0);
    rc("dataHeld", D, 2'h0, 8'hA5);
    chk("flagsR", 8'h03, {6'h00, nvIrqFlag, mfIrqFlag});
    fin("read");
    // Both triggers qualify at once: the write runs, the read is dropped
    wc(8'h0A);
    wc(8'h0F);
    run = 0;
    idle();
    chk("bothLen", 8'(WC), 8'(run));
    rc("bothCtrl", C, 2'h3, 8'h0A);
    wc(8'h00);
    fin("both");
    // Vector request over every enable and stack combination
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      #1 {globalIntEn, nvIrqEnable, mfIntEnable, stackFull} = i[3:0];
      repeat (2) @(posedge clk);
      #1 chk("vector", {7'h00, i[3:0] == 4'hE}, {7'h00, vectorRequest});
    end
    {globalIntEn, nvIrqEnable, mfIntEnable, stackFull} = 4'h0;
    fin("vector");
    conclude();
  end
endmodule // testbench
